// ### hdl/oad_pkg.sv
/*
 * Shared constants and types for the operand address decoder: field
 * positions, base addresses, state costs and the enumerations.
 * Assumes a single 10 MHz system clock and 24-bit code addresses.
 */
package oad_pkg;

	// Timing: one state is this many system clock cycles
	localparam int STATE_CLKS = 2;
	localparam int CLK_PERIOD_NS = 100;

	// Widths
	localparam int ADDR_W = 24;
	localparam int LEN_W = 3;
	localparam int ST_W = 8;
	localparam int WS_W = 3;
	localparam int QDEPTH = 8;

	// Fetch and state costs
	localparam logic [1:0] INT_FETCH_BYTES = 2'h2;
	localparam logic [7:0] NONPAGE_BASE = 8'h02;
	localparam logic [7:0] PAGE_BYTE_COST = 8'h01;
	localparam logic [7:0] IO_EXTRA = 8'h01;
	localparam logic [7:0] PERIPH_EXTRA = 8'h02;
	localparam logic [7:0] ALE_EXTRA = 8'h01;

	// Address map values
	localparam logic [7:0] LEGACY_RAM_BASE = 8'h20;
	localparam logic [7:0] EXT_BIT_LO = 8'h20;
	localparam int SFR_SEL_BIT = 7;
	localparam logic [15:0] UPPER_ONES = 16'hFFFF;
	localparam logic [7:0] IO_PORT0 = 8'h80;
	localparam logic [7:0] IO_PORT1 = 8'h90;
	localparam logic [7:0] IO_PORT2 = 8'hA0;
	localparam logic [7:0] IO_PORT3 = 8'hB0;

	// Reset values
	localparam logic [7:0] CNT_RST = 8'h00;

	typedef enum logic [3:0] {
		k_short_direct, k_long_direct, k_imm_byte, k_word_imm, k_zero_ext,
		k_ones_ext, k_short_imm, k_legacy_bit, k_ext_bit, k_rel, k_block,
		k_region, k_full
	} oad_kind_t;

	typedef enum logic [2:0] {sp_none, sp_ram, sp_sfr, sp_mem, sp_code} oad_space_t;
	typedef enum logic [1:0] {w_byte, w_word, w_dword} oad_width_t;
	typedef enum logic {fs_idle, fs_run} oad_fsm_t;

endpackage

// ### hdl/oad_state_tick.sv
/*
 * State-rate divider: one-cycle enable pulse every DIV system clocks.
 * Assumes a free-running system clock and asynchronous active-low reset.
 */
`timescale 1ns/1ns
module oad_state_tick #(
	parameter int DIV = oad_pkg::STATE_CLKS
) (
	input wire logic mclk, // System clock
	input wire logic arst_n, // Async reset, active low
	output logic tick // One pulse per state
);
	import oad_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} oad_tick_t;

	oad_tick_t t_q, t_d;

	// Count clocks and fire on the last one of each state
	always_comb begin
		t_d = t_q;
		t_d.tick = (t_q.cnt == 8'(DIV - 1));
		t_d.cnt = t_d.tick ? CNT_RST : t_q.cnt + 8'h01;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign tick = t_q.tick;
endmodule

// ### hdl/oad_fill_count.sv
/*
 * Prefetch queue occupancy in bytes: pushes from the fetch side, pops
 * by instruction length. Assumes the caller never pushes past room
 * and never pops more than the current fill.
 */
`timescale 1ns/1ns
module oad_fill_count #(
	parameter int DEPTH = oad_pkg::QDEPTH,
	parameter int FW = $clog2(DEPTH + 1)
) (
	input wire logic mclk, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [1:0] push_n, // Bytes fetched this cycle
	input wire logic [oad_pkg::LEN_W-1:0] pop_n, // Bytes consumed
	output logic [FW-1:0] fill, // Bytes held
	output logic [FW-1:0] room // Free byte slots
);
	import oad_pkg::*;

	typedef struct packed {
		logic [FW-1:0] fill;
	} oad_fill_t;

	oad_fill_t f_q, f_d;

	// Push and pop may coincide; both move the level in one step
	always_comb begin
		f_d = f_q;
		f_d.fill = f_q.fill + FW'(push_n) - FW'(pop_n);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end

	assign fill = f_q.fill;
	assign room = FW'(DEPTH) - f_q.fill;
endmodule

// ### hdl/oad_decode.sv
/*
 * Operand address decoder with fetch-throughput pacing. Decodes direct,
 * immediate, bit and branch operand fields and paces each instruction
 * for the larger of its execution and fetch-limited state counts.
 * Assumes strap pins from outside the clock domain and an instruction
 * requester on mclk that holds its request until acknowledged.
 */
`timescale 1ns/1ns

// Summary of operation
// - one state equals two system clocks
// - on-chip code fetched two bytes per state
// - external code buffered ahead in prefetch queue
// - fetch minimum: size, or size times waits+2
// - run for larger of execution and fetch
// - io port register access adds states
// - external code, data, SFRs, ALE add time
// - short direct: low half RAM, high SFR
// - short direct width from other operand
// - long direct reaches lowest 64 Kbyte
// - byte and word immediates from instruction
// - word immediate extended with zeros or ones
// - short immediate only one, two, four
// - legacy bits low half: RAM 20h-2Fh
// - legacy bits high half: SFRs x0h, x8h
// - extended bit: RAM 20h-7Fh or SFR
// - relative: signed byte plus next address
// - block target keeps next 2 Kbyte block
// - region target keeps next 64 Kbyte region
// - full target spans whole address space
module oad_decode #(
	parameter int DEPTH = oad_pkg::QDEPTH,
	parameter int FW = $clog2(DEPTH + 1)
) (
	input wire logic mclk, // System clock, 10 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic code_ext_pin, // Code runs from external memory
	input wire logic page_mode_pin, // External memory in page mode
	input wire logic [oad_pkg::WS_W-1:0] wait_states_pin, // Wait states
	input wire logic ale_stretch_pin, // Address-latch pulse stretched
	input wire logic ins_valid, // Instruction request
	input wire logic [oad_pkg::LEN_W-1:0] ins_len, // Size in bytes
	input wire logic [oad_pkg::ST_W-1:0] ins_states, // Execution states
	input wire logic ins_ext_data, // Touches external data
	input wire oad_pkg::oad_kind_t ins_kind, // Operand kind
	input wire logic [oad_pkg::ADDR_W-1:0] ins_field, // Operand field
	input wire oad_pkg::oad_width_t ins_width, // Width of other operand
	input wire logic [oad_pkg::ADDR_W-1:0] ins_next_pc, // Next instr address
	output logic ins_ack, // Request taken, results valid
	output logic ins_stall, // Waiting for queue bytes
	output logic busy, // Instruction in progress
	output logic done, // Instruction finished
	output logic [oad_pkg::ST_W-1:0] run_states, // States charged
	output oad_pkg::oad_space_t dec_space, // Decoded space
	output logic [oad_pkg::ADDR_W-1:0] dec_addr, // Address or target
	output oad_pkg::oad_width_t dec_width, // Access width
	output logic [2:0] dec_bitpos, // Bit within byte
	output logic [31:0] dec_value, // Immediate constant
	output logic dec_error, // Field not encodable
	output logic [FW-1:0] queue_fill // Prefetch queue level
);
	import oad_pkg::*;

	typedef struct packed {
		logic ext1;
		logic ext2;
		logic pg1;
		logic pg2;
		logic ale1;
		logic ale2;
		logic [WS_W-1:0] ws1;
		logic [WS_W-1:0] ws2;
		oad_fsm_t fsm;
		logic [7:0] run_cnt;
		logic [7:0] run_tot;
		logic [7:0] ftmr;
		logic ack;
		logic stall;
		logic busy;
		logic done;
		logic err;
		oad_space_t space;
		oad_width_t width;
		logic [2:0] bitpos;
		logic [ADDR_W-1:0] addr;
		logic [31:0] value;
	} oad_core_t;

	oad_core_t s_q, s_d;
	logic state_tick;
	logic [FW-1:0] fill;
	logic [FW-1:0] room;
	logic [1:0] push_n;
	logic [LEN_W-1:0] pop_n;
	logic take;
	logic [7:0] fill8;
	logic [7:0] byte_cost;
	logic [7:0] np_cost;
	logic [7:0] fmin;
	logic [7:0] exec;
	logic [7:0] extra;
	logic [7:0] sfr_adr;
	logic sfr_hit;

	oad_state_tick #(
		.DIV(STATE_CLKS)
	) u_tick (
		.mclk(mclk),
		.arst_n(arst_n),
		.tick(state_tick)
	);

	oad_fill_count #(
		.DEPTH(DEPTH),
		.FW(FW)
	) u_fill (
		.mclk(mclk),
		.arst_n(arst_n),
		.push_n(push_n),
		.pop_n(pop_n),
		.fill(fill),
		.room(room)
	);

	assign fill8 = 8'(fill);

	// Fetch costs; non-page cost also prices external data accesses
	always_comb begin
		np_cost = 8'(s_q.ws2) + NONPAGE_BASE;
		byte_cost = s_q.pg2 ? PAGE_BYTE_COST : np_cost;
	end

	// Request is taken only when the queue already holds the whole
	// instruction; ack gap stops a held request being taken twice
	always_comb begin
		take = (s_q.fsm == fs_idle) && ins_valid && !s_q.ack && (ins_len != '0)
			&& (fill8 >= 8'(ins_len));
	end

	// Main next-state process: pin sync, fetch, decode, pacing
	always_comb begin
		s_d = s_q;
		push_n = 2'h0;
		pop_n = '0;
		fmin = 8'h00;
		exec = 8'h00;
		extra = 8'h00;
		sfr_adr = 8'h00;
		sfr_hit = 1'b0;

		// Two-stage synchronisers for the strap pins
		s_d.ext1 = code_ext_pin;
		s_d.ext2 = s_q.ext1;
		s_d.pg1 = page_mode_pin;
		s_d.pg2 = s_q.pg1;
		s_d.ale1 = ale_stretch_pin;
		s_d.ale2 = s_q.ale1;
		s_d.ws1 = wait_states_pin;
		s_d.ws2 = s_q.ws1;
		s_d.ack = 1'b0;
		s_d.done = 1'b0;

		// Fetch side advances once per state
		if (state_tick) begin
			if (!s_q.ext2) begin
				if (room >= FW'(INT_FETCH_BYTES)) begin
					push_n = INT_FETCH_BYTES;
				end else if (room != '0) begin
					push_n = 2'h1;
				end
				s_d.ftmr = CNT_RST;
			end else if (room != '0) begin
				if (s_q.ftmr + 8'h01 >= byte_cost) begin
					push_n = 2'h1;
					s_d.ftmr = CNT_RST;
				end else begin
					s_d.ftmr = s_q.ftmr + 8'h01;
				end
			end
		end

		s_d.stall = (s_q.fsm == fs_idle) && ins_valid && !s_q.ack
			&& (fill8 < 8'(ins_len));

		if (take) begin
			pop_n = ins_len;
			s_d.ack = 1'b1;
			s_d.err = 1'b0;
			s_d.space = sp_none;
			s_d.addr = '0;
			s_d.value = '0;
			s_d.bitpos = 3'h0;
			s_d.width = w_byte;
			case (ins_kind)
				k_short_direct: begin
					s_d.addr = {16'h0000, ins_field[7:0]};
					s_d.space = ins_field[SFR_SEL_BIT] ? sp_sfr : sp_ram;
					sfr_hit = ins_field[SFR_SEL_BIT];
					sfr_adr = ins_field[7:0];
					s_d.width = ins_width;
				end
				k_long_direct: begin
					s_d.addr = {8'h00, ins_field[15:0]};
					s_d.space = sp_mem;
					s_d.width = ins_width;
				end
				k_imm_byte: begin
					s_d.value = {24'h000000, ins_field[7:0]};
				end
				k_word_imm: begin
					s_d.value = {16'h0000, ins_field[15:0]};
					s_d.width = w_word;
				end
				k_zero_ext: begin
					s_d.value = {16'h0000, ins_field[15:0]};
					s_d.width = w_dword;
				end
				k_ones_ext: begin
					s_d.value = {UPPER_ONES, ins_field[15:0]};
					s_d.width = w_dword;
				end
				k_short_imm: begin
					case (ins_field[1:0])
						2'h0: s_d.value = 32'h00000001;
						2'h1: s_d.value = 32'h00000002;
						2'h2: s_d.value = 32'h00000004;
						default: s_d.err = 1'b1;
					endcase
				end
				k_legacy_bit: begin
					s_d.bitpos = ins_field[2:0];
					if (ins_field[7]) begin
						s_d.addr = {16'h0000, ins_field[7:3], 3'h0};
						s_d.space = sp_sfr;
						sfr_hit = 1'b1;
						sfr_adr = {ins_field[7:3], 3'h0};
					end else begin
						s_d.addr = {16'h0000, LEGACY_RAM_BASE + {4'h0, ins_field[6:3]}};
						s_d.space = sp_ram;
					end
				end
				k_ext_bit: begin
					s_d.bitpos = ins_field[2:0];
					s_d.addr = {16'h0000, ins_field[10:3]};
					if (ins_field[10]) begin
						s_d.space = sp_sfr;
						sfr_hit = 1'b1;
						sfr_adr = ins_field[10:3];
					end else if (ins_field[10:3] >= EXT_BIT_LO) begin
						s_d.space = sp_ram;
					end else begin
						s_d.err = 1'b1;
					end
				end
				k_rel: begin
					s_d.addr = ins_next_pc + {{16{ins_field[7]}}, ins_field[7:0]};
					s_d.space = sp_code;
				end
				k_block: begin
					s_d.addr = {ins_next_pc[23:11], ins_field[10:0]};
					s_d.space = sp_code;
				end
				k_region: begin
					s_d.addr = {ins_next_pc[23:16], ins_field[15:0]};
					s_d.space = sp_code;
				end
				k_full: begin
					s_d.addr = ins_field;
					s_d.space = sp_code;
				end
				default: begin
					s_d.err = 1'b1;
				end
			endcase

			if (sfr_hit) begin
				if (sfr_adr == IO_PORT0 || sfr_adr == IO_PORT1
					|| sfr_adr == IO_PORT2 || sfr_adr == IO_PORT3) begin
					extra = IO_EXTRA;
				end else begin
					extra = PERIPH_EXTRA;
				end
			end
			if (ins_ext_data) begin
				extra = extra + np_cost;
			end
			if (s_q.ale2 && (s_q.ext2 || ins_ext_data)) begin
				extra = extra + ALE_EXTRA;
			end
			exec = ins_states + extra;

			if (s_q.ext2) begin
				fmin = s_q.pg2 ? 8'(ins_len) : 8'(ins_len) * np_cost;
			end

			s_d.run_tot = (exec > fmin) ? exec : fmin;
			if (s_d.run_tot == 8'h00) begin
				s_d.run_tot = 8'h01;
			end
			s_d.run_cnt = CNT_RST;
			s_d.busy = 1'b1;
		end

		// Pacing: charge one state per tick until the total is spent
		case (s_q.fsm)
			fs_idle: begin
				if (take) begin
					s_d.fsm = fs_run;
				end
			end
			fs_run: begin
				if (state_tick) begin
					if (s_q.run_cnt + 8'h01 >= s_q.run_tot) begin
						s_d.fsm = fs_idle;
						s_d.busy = 1'b0;
						s_d.done = 1'b1;
					end else begin
						s_d.run_cnt = s_q.run_cnt + 8'h01;
					end
				end
			end
			default: begin
				s_d.fsm = fs_idle;
			end
		endcase
	end

	// Single state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ins_ack = s_q.ack;
	assign ins_stall = s_q.stall;
	assign busy = s_q.busy;
	assign done = s_q.done;
	assign run_states = s_q.run_tot;
	assign dec_space = s_q.space;
	assign dec_addr = s_q.addr;
	assign dec_width = s_q.width;
	assign dec_bitpos = s_q.bitpos;
	assign dec_value = s_q.value;
	assign dec_error = s_q.err;
	assign queue_fill = fill;

	// Checks of the decode and pacing behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence s_accept_kind(oad_kind_t k);
		take && ins_kind == k;
	endsequence

	sequence s_quiet_tick;
		state_tick && pop_n == '0;
	endsequence

	a_tick_spacing: assert property (
		state_tick |=> !state_tick ##1 state_tick)
		else $error("state tick not every two clocks");

	a_int_word_fetch: assert property (
		(s_quiet_tick and (!s_q.ext2 && room >= FW'(INT_FETCH_BYTES)))
		|=> fill == $past(fill) + FW'(INT_FETCH_BYTES))
		else $error("on-chip fetch did not add two bytes");

	a_page_byte_rate: assert property (
		(s_quiet_tick and (s_q.ext2 && s_q.pg2 && room != '0))
		|=> fill == $past(fill) + FW'(1))
		else $error("page mode fetch not one byte per state");

	a_run_bound: assert property (
		take |=> run_states >= $past(ins_states) && run_states >= $past(fmin)
		&& busy && ins_ack)
		else $error("run length below execution or fetch bound");

	a_port_extra: assert property (
		(take && sfr_hit && sfr_adr == IO_PORT1 && !ins_ext_data && !s_q.ale2
		&& !s_q.ext2 && ins_states != 8'hFF)
		|=> run_states == $past(ins_states) + IO_EXTRA)
		else $error("port access did not add a state");

	a_stall_flag: assert property (
		(s_q.fsm == fs_idle && ins_valid && !s_q.ack && fill8 < 8'(ins_len))
		|=> ins_stall && !ins_ack)
		else $error("short queue not flagged as stall");

	a_direct_split: assert property (
		s_accept_kind(k_short_direct)
		|=> dec_space == ($past(ins_field[7]) ? sp_sfr : sp_ram))
		else $error("short direct space wrong");

	a_ones_fill: assert property (
		s_accept_kind(k_ones_ext)
		|=> dec_value[31:16] == UPPER_ONES && dec_value[15:0] == $past(ins_field[15:0]))
		else $error("ones extension wrong");

	a_short_const: assert property (
		s_accept_kind(k_short_imm)
		|=> dec_error || dec_value == 32'h1 || dec_value == 32'h2 || dec_value == 32'h4)
		else $error("short immediate outside one two four");

	a_legacy_ram: assert property (
		(s_accept_kind(k_legacy_bit) and !ins_field[7])
		|=> dec_addr >= 24'h000020 && dec_addr <= 24'h00002F && dec_space == sp_ram)
		else $error("legacy bit RAM byte wrong");

	a_rel_target: assert property (
		s_accept_kind(k_rel)
		|=> dec_addr == $past(ins_next_pc) + {{16{$past(ins_field[7])}}, $past(ins_field[7:0])})
		else $error("relative target wrong");

	a_block_keep: assert property (
		s_accept_kind(k_block) |=> dec_addr[23:11] == $past(ins_next_pc[23:11]))
		else $error("block target left its block");

	a_done_ends: assert property (
		done |-> !busy ##1 !done)
		else $error("done pulse malformed");
endmodule

// ### verification/oad_code_feed.sv
/*
 * Instruction source model standing for the program memory side: it
 * presents one request at a time and holds it until acknowledged.
 * Assumes go pulses only while idle is high, on the mclk domain.
 */
`timescale 1ns/1ns
module oad_code_feed (
	input wire logic mclk, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic go, // Start one request
	input wire logic [65:0] req, // Packed request fields
	input wire logic ins_ack, // Acknowledge from decoder
	output logic ins_valid, // Request to decoder
	output logic [65:0] ins_bus, // Fields seen by decoder
	output logic idle // No request outstanding
);
	// Hold until ack; released fields toggle so stale values never pass
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ins_valid <= 1'b0;
			ins_bus <= '0;
		end else if (ins_valid && ins_ack) begin
			ins_valid <= 1'b0;
			ins_bus <= ~ins_bus;
		end else if (go) begin
			ins_valid <= 1'b1;
			ins_bus <= req;
		end else if (!ins_valid) begin
			ins_bus <= ~ins_bus;
		end
	end

	// Idle stays low during the cycle of a pending go
	assign idle = !ins_valid && !go;
endmodule

// ### verification/operand_address_decode_tb.sv
/*
 * Self-checking bench for the operand address decoder: directed and
 * random operands under several fetch configurations.
 * Assumes the design package and the instruction source model.
 */
`timescale 1ns/1ns
module operand_address_decode_tb;
	import oad_pkg::*;
	typedef struct {
		oad_kind_t k;
		oad_space_t sp;
		logic [23:0] a;
		oad_width_t w;
		logic [2:0] b;
		logic [31:0] v;
		logic e;
		logic [7:0] rs;
	} oad_note_t;
	logic mclk, arst_n, code_ext_pin, page_mode_pin, ale_stretch_pin, go;
	logic ins_valid, ins_ack, ins_stall, busy, done, dec_error, idle, ins_ext_data;
	logic [2:0] wait_states_pin, ins_len, dec_bitpos;
	logic [65:0] req, bus;
	logic [7:0] ins_states, run_states;
	logic [23:0] ins_field, ins_next_pc, dec_addr;
	logic [31:0] dec_value;
	logic [3:0] queue_fill, fill_p;
	logic [2:0] len_p;
	logic stall_p = 1'b0;
	logic pend = 1'b0;
	oad_kind_t ins_kind;
	oad_width_t ins_width, dec_width;
	oad_space_t dec_space;
	oad_note_t notes[$];
	oad_note_t mn;
	int bad_count, n_tests, cyc, seed, wait_c;
	// Boundary operands: kind code in the top nibble, field below
	localparam logic [27:0] DIR [27] = '{28'h000007F, 28'h0000080, 28'h0000090,
		28'h00000A0, 28'h00000B0, 28'h00000C0, 28'h6000000, 28'h6000001, 28'h6000002,
		28'h6000003, 28'h80000FF, 28'h8000100, 28'h80003FF, 28'h8000400, 28'h8000487,
		28'h700007F, 28'h7000080, 28'h70000FF, 28'h9000080, 28'h900007F, 28'hA0007FF,
		28'hB00FFFF, 28'hCFFFFFF, 28'h5008000, 28'h4008001, 28'h3001234, 28'h100ABCD};

	oad_code_feed feed (.mclk(mclk), .arst_n(arst_n), .go(go), .req(req),
		.ins_ack(ins_ack), .ins_valid(ins_valid), .ins_bus(bus), .idle(idle));
	// Request layout: len, states, ext data, field, next pc, kind, width
	assign {ins_len, ins_states, ins_ext_data, ins_field, ins_next_pc} = bus[65:6];
	assign ins_kind = oad_kind_t'(bus[5:2]);
	assign ins_width = oad_width_t'(bus[1:0]);

	oad_decode #(.DEPTH(8)) uut (.mclk(mclk), .arst_n(arst_n), .code_ext_pin(code_ext_pin),
		.page_mode_pin(page_mode_pin), .wait_states_pin(wait_states_pin),
		.ale_stretch_pin(ale_stretch_pin), .ins_valid(ins_valid), .ins_len(ins_len),
		.ins_states(ins_states), .ins_ext_data(ins_ext_data), .ins_kind(ins_kind),
		.ins_field(ins_field), .ins_width(ins_width), .ins_next_pc(ins_next_pc),
		.ins_ack(ins_ack), .ins_stall(ins_stall), .busy(busy), .done(done),
		.run_states(run_states), .dec_space(dec_space), .dec_addr(dec_addr),
		.dec_width(dec_width), .dec_bitpos(dec_bitpos), .dec_value(dec_value),
		.dec_error(dec_error), .queue_fill(queue_fill));

	// 10 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Work out the expected decode and state count, note it, then hand over
	task automatic issue(input oad_kind_t k, input logic [23:0] f, input logic [2:0] len,
		input logic [7:0] st, input logic xd, input oad_width_t w, input logic [23:0] npc);
		oad_note_t n;
		logic [7:0] by, ex, fm, ws;
		logic sfr;
		n = '{k, sp_none, 24'h0, w, f[2:0], 32'h0, 1'b0, 8'h0};
		by = f[7:0];
		sfr = 1'b0;
		ws = {5'h0, wait_states_pin};
		case (k)
			k_short_direct: begin
				sfr = by[7];
				n.a = {16'h0, by};
			end
			k_long_direct: begin
				n.sp = sp_mem;
				n.a = {8'h0, f[15:0]};
			end
			k_imm_byte: n.v = {24'h0, by};
			k_word_imm, k_zero_ext: n.v = {16'h0, f[15:0]};
			k_ones_ext: n.v = {16'hFFFF, f[15:0]};
			k_short_imm: begin
				n.v = 32'h1 << f[1:0];
				n.e = f[1:0] == 2'h3;
			end
			k_legacy_bit: begin
				sfr = by[7];
				n.a = sfr ? {16'h0, by[7:3], 3'h0} : {16'h0, 4'h2, by[6:3]};
			end
			k_ext_bit: begin
				by = f[10:3];
				sfr = by[7];
				n.e = by < 8'h20;
				n.a = {16'h0, by};
			end
			k_rel: n.a = npc + {{16{by[7]}}, by};
			k_block: n.a = {npc[23:11], f[10:0]};
			k_region: n.a = {npc[23:16], f[15:0]};
			default: n.a = f;
		endcase
		if (k == k_short_direct || k == k_legacy_bit || k == k_ext_bit)
			n.sp = sfr ? sp_sfr : sp_ram;
		if (k >= k_rel)
			n.sp = sp_code;
		ex = !sfr ? 8'h0 : (n.a[7:0] inside {8'h80, 8'h90, 8'hA0, 8'hB0}) ? 8'h1 : 8'h2;
		if (xd)
			ex = ex + ws + 8'h2;
		if (ale_stretch_pin && (code_ext_pin || xd))
			ex = ex + 8'h1;
		fm = !code_ext_pin ? 8'h0 : page_mode_pin ? {5'h0, len} : {5'h0, len} * (ws + 8'h2);
		n.rs = (st + ex > fm) ? st + ex : fm;
		if (n.rs == 8'h0)
			n.rs = 8'h1;
		forever begin
			@(posedge mclk);
			if (idle)
				break;
		end
		notes.push_back(n);
		go <= 1'b1;
		req <= {len, st, xd, f, npc, k, w};
		@(posedge mclk);
		go <= 1'b0;
	endtask

	// Drain everything, then change the fetch configuration
	task automatic set_mode(input int c);
		while (!(idle && !busy && !pend && notes.size() == 0))
			@(posedge mclk);
		code_ext_pin <= c > 1;
		page_mode_pin <= c == 2;
		wait_states_pin <= c == 5 ? 3'h7 : c == 4 ? 3'h4 : c == 2 ? 3'h3 : 3'h0;
		ale_stretch_pin <= c[0];
		repeat (12) @(posedge mclk);
		if (c < 2) check(queue_fill, 8, "fill");
	endtask

	// Result watcher: pairs each acknowledge with the oldest note
	always @(posedge mclk) begin
		if (arst_n) begin
			cyc++;
			if (cyc > 90000) begin
				bad_count++;
				summarize();
			end
			if (pend)
				wait_c++;
			if (stall_p && ins_valid && !ins_ack && !busy && queue_fill < ins_len)
				check(ins_stall, 1, "stall");
			if (done === 1'b1) begin
				check(pend, 1, "done");
				check(wait_c >= 2 * mn.rs - 1 && wait_c <= 2 * mn.rs + 1, 1, "span");
				pend = 1'b0;
			end
			if (ins_ack === 1'b1) begin
				check(fill_p >= len_p, 1, "take");
				if (notes.size() == 0) begin
					check(0, 1, "note");
				end else begin
					mn = notes.pop_front();
					pend = 1'b1;
					wait_c = 0;
					case (mn.k)
						k_short_direct, k_long_direct: begin
							check(dec_space, mn.sp, "space");
							check(dec_addr, mn.a, "addr");
							check(dec_width, mn.w, "width");
						end
						k_legacy_bit, k_ext_bit: begin
							check(dec_error, mn.e, "error");
							if (!mn.e) check({dec_space, dec_bitpos, dec_addr},
								{mn.sp, mn.b, mn.a}, "bit");
						end
						k_rel, k_block, k_region, k_full: begin
							check({dec_space, dec_addr}, {mn.sp, mn.a}, "target");
						end
						default: begin
							check(dec_error, mn.e, "error");
							if (!mn.e) check(dec_value, mn.v, "value");
						end
					endcase
					check(run_states, mn.rs, "states");
				end
			end
			stall_p = ins_valid && !ins_ack && !busy && queue_fill < ins_len;
			fill_p = queue_fill;
			len_p = ins_len;
		end
	end

	// Main sequence: reset, then each configuration with boundary and random operands
	initial begin
		seed = 59;
		{arst_n, code_ext_pin, page_mode_pin, ale_stretch_pin, go} = 5'h0;
		{wait_states_pin, req} = '0;
		repeat (2) @(posedge mclk);
		check({busy, done, ins_ack, dec_space}, 0, "reset");
		arst_n <= 1'b1;
		for (int c = 0; c < 6; c++) begin
			set_mode(c);
			foreach (DIR[i])
				issue(oad_kind_t'(DIR[i][27:24]), DIR[i][23:0], 3'h3, 8'h2, 1'b0, w_word,
					24'(DIR[i]) ^ 24'hFFFFF0);
			repeat (15)
				issue(oad_kind_t'($unsigned($random(seed)) % 13), 24'($random(seed)),
					3'(1 + $unsigned($random(seed)) % 7), 8'($unsigned($random(seed)) % 24),
					1'($random(seed)), oad_width_t'($unsigned($random(seed)) % 3),
					24'($random(seed)));
		end
		set_mode(0);
		summarize();
	end
endmodule
